//--- logic/bds_params.svh
`ifndef BDS_PARAMS_SVH
`define BDS_PARAMS_SVH

// Conversion timing in converter clock cycles.
`define BDS_CONV_CYCLES   16'h9c42
`define BDS_BUSY_CYCLES   16'h7531
`define BDS_DIGIT_CYCLES  8'hc8
`define BDS_STROBE_AT     8'h64
`define BDS_UPDATE_CYCLES 10'h320
`define BDS_LEAD_INDEX    3'h4
`define BDS_LEAD_NUMBER   3'h5
`define BDS_NO_DIGIT      3'h0

// Scan numbering after the end of a measurement.
`define BDS_SCAN_UPDATE   2'h0
`define BDS_SCAN_STROBED  2'h1
`define BDS_SCAN_PLAIN    2'h2

// Serial framing: start, eight data, parity, stop.
`define BDS_BIT_CYCLES    5'h10
`define BDS_HALF_BIT      5'h08
`define BDS_TX_BITS       4'hb
// The receiver samples the start bit, eight data bits and parity.
`define BDS_RX_BITS       4'ha
`define BDS_OVER_VALUE    4'hf

// Register map on the APB side of the capture end.
`define BDS_REG_CTRL      8'h00
`define BDS_REG_STATUS    8'h04
`define BDS_REG_READING   8'h08
`define BDS_REG_RX        8'h0c
`define BDS_REG_TIMED     8'h10

// Control bits.
`define BDS_CTRL_FREE_RUN 0
`define BDS_CTRL_UART_RUN 1
`define BDS_CTRL_MUX      2
`define BDS_CTRL_TX_EN    3
`define BDS_CTRL_RESET    4'h0

// Status bits.
`define BDS_STAT_NEW      0

`endif

//--- logic/bds_pkg.sv
package bds_pkg;

    typedef enum logic [1:0] {
        bds_hold = 2'h0,
        bds_meas = 2'h1,
        bds_scan = 2'h3
    } bds_state_t;

    // Index 4 is the leading digit, index 0 the trailing digit.
    typedef logic [4:0][3:0] bds_digits_t;

endpackage

//--- logic/bds_link_if.sv
`timescale 1ns/1ps
interface bds_link_if;
    logic [4:0] digit_select;
    logic [3:0] bcd;
    logic       strobe;
    logic       busy;
    logic       over_range;
    logic       reading_too_low;
    logic       polarity;
    logic       run_hold;

    modport device (
        output digit_select,
        output bcd,
        output strobe,
        output busy,
        output over_range,
        output reading_too_low,
        output polarity,
        input  run_hold
    );

    modport host (
        input  digit_select,
        input  bcd,
        input  strobe,
        input  busy,
        input  over_range,
        input  reading_too_low,
        input  polarity,
        output run_hold
    );
endinterface

//--- logic/bds_converter_end.sv
`timescale 1ns/1ps
`include "bds_params.svh"
module bds_converter_end
    import bds_pkg::*;
#(
    parameter logic [15:0] CONV_CYCLES = `BDS_CONV_CYCLES,
    parameter logic [15:0] BUSY_CYCLES = `BDS_BUSY_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    bds_link_if.device       link,
    input  wire logic [15:0] meas_lower,
    input  wire logic        meas_half,
    input  wire logic        meas_positive,
    input  wire logic        meas_over,
    input  wire logic        meas_under,
    output logic             reading_taken
);
    bds_state_t  state;
    bds_state_t  next_state;
    logic [15:0] cnt;
    logic [7:0]  ph;
    logic [2:0]  dig;
    logic [1:0]  scan;
    bds_digits_t shown;
    logic [15:0] pend;
    logic        pol;
    logic        over;
    logic        under;

    wire busy_end = (state == bds_meas) && (cnt == BUSY_CYCLES - 16'h0001);
    wire conv_end = (cnt == CONV_CYCLES - 16'h0001);
    wire ph_end   = (ph == `BDS_DIGIT_CYCLES - 8'h01);
    wire scan_end = ph_end && (dig == 3'h0);
    wire restart  = (state == bds_hold) || ((state == bds_scan) && conv_end);

    always_comb begin
        case (state)
            bds_hold: next_state = link.run_hold ? bds_meas : bds_hold;
            bds_meas: next_state = busy_end ? bds_scan : bds_meas;
            bds_scan: begin
                if (!conv_end)
                    next_state = bds_scan;
                else
                    next_state = link.run_hold ? bds_meas : bds_hold;
            end
            default: next_state = bds_hold;
        endcase
    end

    // A running conversion always spans the full count, so the rate is fixed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= bds_hold;
            cnt   <= 16'h0000;
        end else begin
            state <= next_state;
            cnt   <= restart ? 16'h0000 : cnt + 16'h0001;
        end
    end

    // The scan restarts on the leading digit as soon as the result is ready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph   <= 8'h00;
            dig  <= `BDS_LEAD_INDEX;
            scan <= `BDS_SCAN_PLAIN;
        end else if (busy_end) begin
            ph   <= 8'h00;
            dig  <= `BDS_LEAD_INDEX;
            scan <= `BDS_SCAN_UPDATE;
        end else begin
            ph  <= ph_end ? 8'h00 : ph + 8'h01;
            dig <= scan_end ? `BDS_LEAD_INDEX : (ph_end ? dig - 3'h1 : dig);
            if (scan_end && scan != `BDS_SCAN_PLAIN)
                scan <= scan + 2'h1;
        end
    end

    // The leading digit takes the new reading at once; the lower digits wait
    // for the end of the update scan, so that scan still shows the old ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shown <= '0;
            pend  <= 16'h0000;
            pol   <= 1'b0;
            over  <= 1'b0;
            under <= 1'b0;
        end else if (busy_end) begin
            shown[`BDS_LEAD_INDEX] <= {3'h0, meas_half};
            pend  <= meas_lower;
            pol   <= meas_positive;
            over  <= meas_over;
            under <= meas_under;
        end else if (scan_end && scan == `BDS_SCAN_UPDATE) begin
            shown[3:0] <= pend;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.digit_select    <= 5'h00;
            link.bcd             <= 4'h0;
            link.strobe          <= 1'b0;
            link.busy            <= 1'b0;
            link.over_range      <= 1'b0;
            link.reading_too_low <= 1'b0;
            link.polarity        <= 1'b0;
            reading_taken        <= 1'b0;
        end else begin
            // Outside the strobed scan an over-range reading shows no digit.
            link.digit_select <= (over && scan != `BDS_SCAN_STROBED) ? 5'h00 : (5'h01 << dig);
            link.bcd          <= shown[dig];
            link.strobe       <= (scan == `BDS_SCAN_STROBED) && (ph == `BDS_STROBE_AT);
            link.busy         <= (next_state == bds_meas);
            link.over_range   <= over;
            link.reading_too_low <= under;
            link.polarity     <= pol;
            reading_taken     <= busy_end;
        end
    end
endmodule

//--- logic/bds_capture_end.sv
`timescale 1ns/1ps
`include "bds_params.svh"
// Summary of operation
// - Strobe sits mid-digit, data stable around it.
// - Digit load is select AND strobe.
// - Over-range forces loaded lower digits to all ones.
// - Over-range flags input above full scale.
// - Sign and half digit latched once per reading.
// - Single rank invalid for 800-cycle update.
// - Update shows new leading, old lower digits.
// - Second rank copies on leading select rise.
// - Encode one-hot selects to three-bit digit number.
// - No active select encodes as zero.
// - Busy fall signals a new reading.
// - Optional timed reads after leading select.
// - Each strobe sends one serial word.
// - Upper nibble names digit, lower carries BCD.
// - Polarity drives the even-parity select.
// - Receiver parity flag means positive reading.
// - Receive data ready drives run/hold.
// - Busy fall clears receive data ready.
// - Leading word carries sign and range bits.
// - Word finishes before the next strobe.
// - Conversion lasts exactly 40,002 clock cycles.
module bds_capture_end
    import bds_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    bds_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        receive_serial_in,
    output logic             tx_serial_out,
    output logic             even_parity_select,
    output logic [15:0]      display_digits,
    output logic             half_digit,
    output logic             polarity_latched,
    output logic             blank_low_digits,
    output logic [2:0]       digit_number
);
    logic [3:0]  ctrl;
    logic [4:0]  sel_q;
    logic        busy_q;
    logic        new_reading;
    logic        receive_data_ready;
    bds_digits_t rank1;
    bds_digits_t rank2;
    bds_digits_t timed;
    logic        upd_arm;
    logic [9:0]  upd_cnt;
    logic [7:0]  t_ph;
    logic [2:0]  t_dig;
    logic        t_run;
    logic [10:0] tx_shift;
    logic [3:0]  tx_left;
    logic [4:0]  tx_tick;
    logic        tx_overrun;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_left;
    logic [4:0]  rx_tick;
    logic        rx_active;
    logic [7:0]  rx_word;
    logic        rx_positive;

    // Both ends share pclk, so a one-flop delay is enough for edge detection.
    wire busy_fall = busy_q && !link.busy;
    wire lead_rise = link.digit_select[4] && !sel_q[4];
    wire lead_fall = !link.digit_select[4] && sel_q[4];
    wire [4:0] load = link.digit_select & {5{link.strobe}};
    wire [3:0] value = link.over_range ? `BDS_OVER_VALUE : link.bcd;
    wire [2:0] enc = link.digit_select[4] ? 3'h5 : link.digit_select[3] ? 3'h4 :
                     link.digit_select[2] ? 3'h3 : link.digit_select[1] ? 3'h2 :
                     link.digit_select[0] ? 3'h1 : `BDS_NO_DIGIT;
    wire rank1_valid = !upd_arm && (upd_cnt == 10'h000);
    wire t_end = t_ph == `BDS_DIGIT_CYCLES - 8'h01;

    // Transmit word: digit code in the upper nibble, bits reversed.
    wire [2:0] ord   = `BDS_LEAD_NUMBER - enc;
    wire [3:0] tx_hi = {ord[0], ord[1], ord[2], 1'b0};
    wire       mux   = ctrl[`BDS_CTRL_MUX] && (enc == `BDS_LEAD_NUMBER);
    wire [3:0] tx_lo = mux ? {link.reading_too_low, link.over_range, link.polarity,
                              link.bcd[0]} : link.bcd;
    wire [7:0] tx_data = {tx_hi, tx_lo};
    wire       tx_par  = link.polarity ? ^tx_data : ~^tx_data;
    wire       tx_idle = tx_left == 4'h0;
    wire       tx_go   = ctrl[`BDS_CTRL_TX_EN] && link.strobe;
    wire       tx_tick_end = tx_tick == `BDS_BIT_CYCLES - 5'h01;
    wire       rx_tick_end = rx_tick == `BDS_BIT_CYCLES - 5'h01;
    wire       rx_done = rx_active && rx_tick_end && rx_left == 4'h0;

    // Writes land at the completing edge, when the master samples pready high.
    wire apb_wr = psel && penable && pwrite && pready;
    wire apb_rd = psel && penable && !pwrite && !pready;
    wire hit = (paddr == `BDS_REG_CTRL) || (paddr == `BDS_REG_STATUS) ||
               (paddr == `BDS_REG_READING) || (paddr == `BDS_REG_RX) ||
               (paddr == `BDS_REG_TIMED);
    wire clr_new = apb_wr && (paddr == `BDS_REG_STATUS) && pwdata[`BDS_STAT_NEW];
    wire [31:0] rd_data =
        (paddr == `BDS_REG_CTRL)    ? {28'h000_0000, ctrl} :
        (paddr == `BDS_REG_STATUS)  ? {24'h00_0000, tx_overrun, rx_positive, digit_number,
                                       rank1_valid, receive_data_ready, new_reading} :
        (paddr == `BDS_REG_READING) ? {12'h000, rank2} :
        (paddr == `BDS_REG_RX)      ? {23'h00_0000, rx_positive, rx_word} :
        (paddr == `BDS_REG_TIMED)   ? {12'h000, timed} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl    <= `BDS_CTRL_RESET;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata  <= apb_rd ? rd_data : 32'h0000_0000;
            if (apb_wr && paddr == `BDS_REG_CTRL)
                ctrl <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q       <= 5'h00;
            busy_q      <= 1'b0;
            new_reading <= 1'b0;
            digit_number <= `BDS_NO_DIGIT;
            blank_low_digits <= 1'b0;
        end else begin
            sel_q        <= link.digit_select;
            busy_q       <= link.busy;
            new_reading  <= busy_fall || (new_reading && !clr_new);
            digit_number <= enc;
            blank_low_digits <= link.over_range;
        end
    end

    // Display rank and the once-per-reading sign and half digit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_digits   <= 16'h0000;
            half_digit       <= 1'b0;
            polarity_latched <= 1'b0;
        end else begin
            for (int k = 0; k < 4; k++)
                if (load[k])
                    display_digits[k*4 +: 4] <= value;
            if (load[4]) begin
                half_digit       <= link.bcd[0];
                polarity_latched <= link.polarity;
            end
        end
    end

    // First rank follows each select; it is marked invalid while the lower
    // digits still carry the previous reading after the leading digit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rank1   <= '0;
            rank2   <= '0;
            upd_arm <= 1'b0;
            upd_cnt <= 10'h000;
        end else begin
            for (int k = 0; k < 5; k++)
                if (link.digit_select[k])
                    rank1[k] <= link.bcd;
            if (lead_rise)
                rank2 <= rank1;
            if (busy_fall)
                upd_arm <= 1'b1;
            else if (upd_arm && lead_fall)
                upd_arm <= 1'b0;
            if (upd_arm && lead_fall)
                upd_cnt <= `BDS_UPDATE_CYCLES;
            else if (upd_cnt != 10'h000)
                upd_cnt <= upd_cnt - 10'h001;
        end
    end

    // Timed reads sample each digit mid-slot after the leading select rises.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_ph  <= 8'h00;
            t_dig <= `BDS_LEAD_INDEX;
            t_run <= 1'b0;
            timed <= '0;
        end else if (lead_rise) begin
            t_ph  <= 8'h01;
            t_dig <= `BDS_LEAD_INDEX;
            t_run <= 1'b1;
        end else if (t_run) begin
            t_ph  <= t_end ? 8'h00 : t_ph + 8'h01;
            t_dig <= t_end ? t_dig - 3'h1 : t_dig;
            t_run <= !(t_end && t_dig == 3'h0);
            if (t_ph == `BDS_STROBE_AT)
                timed[t_dig] <= link.bcd;
        end
    end

    // A strobe that finds the transmitter busy is dropped and flagged sticky.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift   <= 11'h7ff;
            tx_left    <= 4'h0;
            tx_tick    <= 5'h00;
            tx_overrun <= 1'b0;
            tx_serial_out <= 1'b1;
            even_parity_select <= 1'b0;
        end else begin
            even_parity_select <= link.polarity;
            tx_serial_out <= tx_shift[0];
            tx_overrun <= (tx_go && !tx_idle) || (tx_overrun && !clr_new);
            if (tx_go && tx_idle) begin
                tx_shift <= {1'b1, tx_par, tx_data, 1'b0};
                tx_left  <= `BDS_TX_BITS;
                tx_tick  <= 5'h00;
            end else if (!tx_idle) begin
                tx_tick <= tx_tick_end ? 5'h00 : tx_tick + 5'h01;
                if (tx_tick_end) begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_left  <= tx_left - 4'h1;
                end
            end
        end
    end

    // Receiver checks even parity; a raised flag marks a positive reading.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_active   <= 1'b0;
            rx_tick     <= 5'h00;
            rx_left     <= 4'h0;
            rx_shift    <= 9'h000;
            rx_word     <= 8'h00;
            rx_positive <= 1'b0;
        end else if (!rx_active) begin
            rx_active <= !receive_serial_in;
            rx_tick   <= `BDS_HALF_BIT;
            rx_left   <= `BDS_RX_BITS;
        end else begin
            rx_tick <= rx_tick_end ? 5'h00 : rx_tick + 5'h01;
            if (rx_tick_end && rx_left != 4'h0) begin
                rx_shift <= {receive_serial_in, rx_shift[8:1]};
                rx_left  <= rx_left - 4'h1;
            end
            if (rx_done) begin
                rx_active   <= 1'b0;
                rx_word     <= rx_shift[7:0];
                rx_positive <= ~^rx_shift;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_data_ready <= 1'b0;
            link.run_hold      <= 1'b0;
        end else begin
            receive_data_ready <= rx_done || (receive_data_ready && !busy_fall);
            link.run_hold <= ctrl[`BDS_CTRL_FREE_RUN] ||
                             (ctrl[`BDS_CTRL_UART_RUN] && receive_data_ready);
        end
    end
endmodule

//--- verif/bds_link_sva.sv
`timescale 1ns/1ps
module bds_link_sva #(
    parameter logic [15:0] CONV_CYCLES = 16'h9c42,
    parameter logic [15:0] BUSY_CYCLES = 16'h7531
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [4:0] digit_select,
    input wire logic [3:0] bcd,
    input wire logic       strobe,
    input wire logic       busy,
    input wire logic       over_range,
    input wire logic       reading_too_low,
    input wire logic       polarity,
    input wire logic       run_hold
);
    logic        busy_q;
    logic [16:0] run_cnt;
    logic        rh_drop;
    logic        had_rise;
    logic [11:0] since_fall;
    logic [2:0]  strobe_n;
    wire         rise = busy && !busy_q;
    wire         fell = !busy && busy_q;
    wire [2:0]   flags = {over_range, reading_too_low, polarity};

    // Period checks are skipped after any gap in run_hold, since a stop adds hold time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q     <= 1'h0;
            run_cnt    <= 17'h0_0000;
            rh_drop    <= 1'h0;
            had_rise   <= 1'h0;
            since_fall <= 12'hfff;
            strobe_n   <= 3'h0;
        end else begin
            busy_q     <= busy;
            run_cnt    <= rise ? 17'h0_0001 : run_cnt + 17'h0_0001;
            rh_drop    <= !rise && (rh_drop || !run_hold);
            had_rise   <= had_rise || rise;
            since_fall <= fell ? 12'h001 : since_fall + {11'h000, since_fall != 12'hfff};
            strobe_n   <= fell ? 3'h0 : strobe_n + {2'h0, strobe};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_STROBE_PULSE: assert property (strobe |=> !strobe)
        else $error("strobe held longer than one cycle");
    AST_STROBE_MID: assert property (strobe |-> $stable({digit_select, bcd}) ##1 $stable({digit_select, bcd})[*8])
        else $error("digit data moved near strobe");
    AST_STROBE_SELECT: assert property (strobe |-> $onehot(digit_select))
        else $error("strobe without one digit select");
    AST_SELECT_ONEHOT: assert property ($onehot0(digit_select))
        else $error("several digit selects active");
    AST_BUSY_LENGTH: assert property (fell |-> run_cnt == {1'h0, BUSY_CYCLES})
        else $error("busy length wrong");
    AST_CONV_PERIOD: assert property (rise && had_rise && !rh_drop |-> run_cnt == {1'h0, CONV_CYCLES})
        else $error("conversion period wrong");
    AST_RUN_START: assert property (rise |-> $past(run_hold))
        else $error("conversion started without run");
    AST_LEAD_FIRST: assert property (fell |-> ##1 (over_range || digit_select == 5'h10))
        else $error("leading digit not shown at update");
    AST_STROBE_WINDOW: assert property (strobe |-> since_fall >= 12'h3e8 && since_fall <= 12'h7d0)
        else $error("strobe outside strobed scan");
    AST_STROBE_COUNT: assert property (since_fall == 12'h7d0 |-> strobe_n == 3'h5)
        else $error("strobe count per reading wrong");
    AST_STROBE_SPACING: assert property (strobe && !digit_select[0] |-> ##200 strobe)
        else $error("strobe spacing wrong");
    AST_FLAGS_AT_END: assert property ($changed(flags) |-> $past(fell))
        else $error("range or sign flags moved outside a reading update");
endmodule

//--- verif/bds_digit_scan_capture_tb_top.sv
`timescale 1ns/1ps
module bds_digit_scan_capture_tb_top;
    localparam logic [15:0] CONV = 16'h1388;
    localparam logic [15:0] BUSY = 16'h09c4;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] meas_lower = 16'h0000;
    logic        meas_half = 1'h0;
    logic        meas_positive = 1'h0;
    logic        meas_over = 1'h0;
    logic        meas_under = 1'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_serial_out;
    logic        even_parity_select;
    logic [15:0] display_digits;
    logic        half_digit;
    logic        polarity_latched;
    logic        blank_low_digits;
    logic [2:0]  digit_number;
    logic        reading_taken;
    int          err_count = 0;
    int          compares = 0;
    int          n;
    logic [31:0] rd;
    logic        sl;
    logic [15:0] lower;
    logic        half;
    logic        pos;
    logic        over;

    // The serial output is looped back so received words can start conversions.
    wire receive_serial_in = tx_serial_out;

    bds_link_if i_bds_link_if ();
    wire busy = i_bds_link_if.busy;

    bds_converter_end #(.CONV_CYCLES(CONV), .BUSY_CYCLES(BUSY)) i_bds_converter_end (
        .pclk, .presetn, .link(i_bds_link_if), .meas_lower, .meas_half, .meas_positive,
        .meas_over, .meas_under, .reading_taken);
    bds_capture_end i_bds_capture_end (
        .pclk, .presetn, .link(i_bds_link_if), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .receive_serial_in, .tx_serial_out, .even_parity_select,
        .display_digits, .half_digit, .polarity_latched, .blank_low_digits, .digit_number);
    bds_link_sva #(.CONV_CYCLES(CONV), .BUSY_CYCLES(BUSY)) i_bds_link_sva (
        .pclk, .presetn, .digit_select(i_bds_link_if.digit_select), .bcd(i_bds_link_if.bcd),
        .strobe(i_bds_link_if.strobe), .busy(i_bds_link_if.busy),
        .over_range(i_bds_link_if.over_range), .reading_too_low(i_bds_link_if.reading_too_low),
        .polarity(i_bds_link_if.polarity), .run_hold(i_bds_link_if.run_hold));

    always #2.5 pclk = ~pclk;

    task automatic summarize();
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk("apb_ready", 32'h0000_0001, {31'h0, pready});
        rd = prdata;
        sl = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_fall();
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        while (busy !== 1'b0 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        chk("busy_fall", 32'h0000_0000, {31'h0, busy || k >= 20000});
        chk("reading_taken", 32'h0000_0001, {31'h0, reading_taken});
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'h8e5c));
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h1, 8'h00, 32'h0000_000d);
        apb(1'h0, 8'h00, 32'h0000_0000);
        chk("ctrl", 32'h0000_000d, rd);
        apb(1'h0, 8'h14, 32'h0000_0000);
        chk("unmapped_err", 1'h1, sl);
        chk("unmapped_data", 32'h0000_0000, rd);
        for (int i = 0; i < 7; i++) begin
            over = (i % 3 == 1);
            half = 1'($urandom);
            pos = 1'($urandom);
            for (int k = 0; k < 4; k++)
                lower[k*4 +: 4] = 4'($urandom % 10);
            meas_lower <= lower;
            meas_half <= half;
            meas_positive <= pos;
            meas_over <= over;
            meas_under <= !over && 1'($urandom);
            if (i == 3)
                apb(1'h1, 8'h00, 32'h0000_000a);
            if (i == 6)
                apb(1'h1, 8'h00, 32'h0000_0002);
            wait_fall();
            repeat (100) @(posedge pclk);
            apb(1'h0, 8'h04, 32'h0000_0000);
            chk("new_reading", 1'h1, rd[0]);
            chk("rank1_early", 1'h0, rd[2] & !over);
            repeat (2040) @(posedge pclk);
            chk("digit_number", over ? 3'h0 : 3'h5, digit_number);
            chk("display", over ? 16'hffff : lower, display_digits);
            chk("polarity", pos, polarity_latched);
            chk("parity_select", pos, even_parity_select);
            chk("blank", over, blank_low_digits);
            apb(1'h0, 8'h04, 32'h0000_0000);
            chk("status", 3'h3, {rd[7], rd[2] | over, rd[0]});
            apb(1'h1, 8'h04, 32'h0000_0001);
            apb(1'h0, 8'h04, 32'h0000_0000);
            chk("new_clear", 1'h0, rd[0]);
            if (!over) begin
                chk("half", half, half_digit);
                apb(1'h0, 8'h08, 32'h0000_0000);
                chk("reading", {half, lower}, rd);
                apb(1'h0, 8'h10, 32'h0000_0000);
                chk("timed", {half, lower}, rd);
                apb(1'h0, 8'h0c, 32'h0000_0000);
                if (i < 6)
                    chk("rx_word", {pos, 4'h2, lower[3:0]}, rd);
            end
        end
        // With the transmitter off no word sets data ready, so the converter must hold.
        apb(1'h0, 8'h04, 32'h0000_0000);
        chk("ready_cleared", 1'h0, rd[1]);
        n = 0;
        repeat (3000) begin
            @(posedge pclk);
            n += busy;
        end
        chk("held", 32'h0000_0000, n);
        apb(1'h1, 8'h00, 32'h0000_0009);
        repeat (5) @(posedge pclk);
        chk("restart", 1'h1, busy);
        summarize();
    end
endmodule
